// ===== inc/uart_pkg.sv
// Shared constants for the idle-line multiprocessor UART block.
package uart_pkg;

  localparam int AW = 3;
  localparam int DW = 16;

  // Register indices on the plain register port.
  localparam logic [AW-1:0] REG_CTRL  = 3'h0;
  localparam logic [AW-1:0] REG_ENAB  = 3'h1;
  localparam logic [AW-1:0] REG_STAT  = 3'h2;
  localparam logic [AW-1:0] REG_BAUD  = 3'h3;
  localparam logic [AW-1:0] REG_TXBUF = 3'h4;
  localparam logic [AW-1:0] REG_RXBUF = 3'h5;

  // Control register fields.
  localparam int C_SRST = 0;
  localparam int C_CH8  = 1;
  localparam int C_PEN  = 2;
  localparam int C_PODD = 3;
  localparam int C_SP2  = 4;
  localparam int C_MM   = 5;
  localparam int C_SYNC = 6;
  localparam int C_WFLT = 7;

  // Enable register fields.
  localparam int E_RXE  = 0;
  localparam int E_TXE  = 1;
  localparam int E_RXIE = 2;
  localparam int E_TXIE = 3;

  // Status register fields.
  localparam int S_RXF  = 0;
  localparam int S_TXR  = 1;
  localparam int S_EMP  = 2;
  localparam int S_RTAG = 3;
  localparam int S_TREQ = 4;
  localparam int S_ERR  = 5;
  localparam int S_FE   = 6;
  localparam int S_PE   = 7;
  localparam int S_OE   = 8;
  localparam int S_BRK  = 9;

  // Reset values and bit counts.
  localparam logic [15:0] BAUD_RESET    = 16'h0010;
  localparam logic [3:0]  IDLE_MARKS    = 4'hA;
  localparam logic [3:0]  TX_IDLE_BITS  = 4'hB;
  localparam logic [3:0]  BITS_LONG     = 4'h8;
  localparam logic [3:0]  BITS_SHORT    = 4'h7;

endpackage

// ===== verilog/uart_idle_line.sv
// UART core with idle-line and address-bit multiprocessor formats.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// How it works
// - UART runs only while clocked-mode select clear.
// - Start, 7/8 data, address, parity, stop bits.
// - Data shifted and sampled LSB first.
// - Transmitter and receiver share one baud divisor.
// - Power-up clear sets soft reset bit.
// - Soft reset clears flags, sets ready/empty.
// - Rx/tx enable bits survive soft reset; irq enables clear.
// - Clearing soft reset starts normal operation.
// - Format select zero picks idle-line format.
// - Ten marks after first stop mean idle.
// - Second stop bit counts as first mark.
// - First character after idle tags address.
// - Wake filter drops non-address characters silently.
// - Wake filter still delivers address characters.
// - Hardware never changes the wake filter bit.
// - Load copies address request to latch, clears.
// - Set latch sends exactly eleven idle bits.
// - Dummy character never reaches the pin.
// - Next character follows the idle period directly.
// - Start edge raises a wake pulse.
// - Format select one picks address-bit format.
module uart_idle_line
  import uart_pkg::*;
(
  input  wire  logic                 mclk,                   // System clock, 50 MHz.
  input  wire  logic                 reset_n,                // Synchronous reset, active low.
  input  wire  logic                 ce,                     // Clock enable, freezes all state.
  input  wire  logic [uart_pkg::AW-1:0] addr,                // Register index.
  input  wire  logic [uart_pkg::DW-1:0] wdata,               // Write data.
  input  wire  logic                 wr_stb,                 // Write strobe.
  input  wire  logic                 rd_stb,                 // Read strobe.
  output logic [uart_pkg::DW-1:0]    rdata,                  // Read data, one cycle later.
  input  wire  logic                 serial_in_pin,          // Receive line.
  output logic                       serial_out_pin,         // Transmit line.
  output logic                       receive_irq_flag,       // Character waiting.
  output logic                       transmit_ready_flag,    // Transmit buffer free.
  output logic                       start_wake              // Low line in idle; one pulse if receiver enabled, else held.
);
  import uart_pkg::*;

  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_ADDR, R_PAR, R_STOP} rx_state_t;
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_ADDR, T_PAR, T_STOP, T_MARK} tx_state_t;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0]    ctrl, next_ctrl;
  logic [3:0]    enab, next_enab;
  logic [15:0]   baud_div, next_baud_div;
  logic [7:0]    transmit_buffer, next_transmit_buffer;
  logic [7:0]    receive_buffer, next_receive_buffer;
  logic          next_receive_irq_flag, next_transmit_ready_flag;
  logic          transmitter_empty_flag, next_transmitter_empty_flag;
  logic          received_address_tag, next_received_address_tag;
  logic          transmit_address_request, next_transmit_address_request;
  logic          framing_error_flag, next_framing_error_flag;
  logic          parity_error_flag, next_parity_error_flag;
  logic          overrun_flag, next_overrun_flag;
  logic          break_flag, next_break_flag;
  logic [DW-1:0] next_rdata;

  // Events from the serial engines.
  logic          rx_done, rx_is_addr, rx_ferr, rx_perr, rx_brk;
  logic [7:0]    rx_word;
  logic          tx_load, tx_idle_now;

  logic          active, receive_error_summary, deliver;

  // The engines only run with soft reset released and the serial mode selected.
  assign active = !ctrl[C_SRST] && !ctrl[C_SYNC];
  assign receive_error_summary = framing_error_flag | parity_error_flag | overrun_flag |
                                 break_flag;
  // With the wake filter set only address characters reach the buffer.
  assign deliver = rx_done && (!ctrl[C_WFLT] || rx_is_addr);

  // Register writes, reads and flag updates; hardware sets win over software clears.
  always_comb
  begin
    next_ctrl                     = ctrl;
    next_enab                     = enab;
    next_baud_div                 = baud_div;
    next_transmit_buffer          = transmit_buffer;
    next_receive_buffer           = receive_buffer;
    next_receive_irq_flag         = receive_irq_flag;
    next_transmit_ready_flag      = transmit_ready_flag;
    next_received_address_tag     = received_address_tag;
    next_transmit_address_request = transmit_address_request;
    next_framing_error_flag       = framing_error_flag;
    next_parity_error_flag        = parity_error_flag;
    next_overrun_flag             = overrun_flag;
    next_break_flag               = break_flag;
    next_rdata                    = '0;
    // Load moves the request to the latch; a same-cycle set wins.
    if (tx_load)
    begin
      next_transmit_ready_flag      = 1'b1;
      next_transmit_address_request = 1'b0;
    end
    if (wr_stb)
    begin
      case (addr)
        REG_CTRL:  next_ctrl = wdata[7:0];           // Wake filter changes only here.
        REG_ENAB:  next_enab = wdata[3:0];
        REG_BAUD:  next_baud_div = wdata;             // One divisor for both directions.
        REG_TXBUF:
        begin
          if (transmit_ready_flag)
          begin
            next_transmit_buffer     = wdata[7:0];
            next_transmit_ready_flag = 1'b0;
          end
        end
        REG_STAT:
        begin
          if (wdata[S_RXF]) next_receive_irq_flag = 1'b0;
          if (wdata[S_FE])  next_framing_error_flag = 1'b0;
          if (wdata[S_PE])  next_parity_error_flag = 1'b0;
          if (wdata[S_OE])  next_overrun_flag = 1'b0;
          if (wdata[S_BRK]) next_break_flag = 1'b0;
          if (wdata[S_TREQ]) next_transmit_address_request = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd_stb)
    begin
      case (addr)
        REG_CTRL:  next_rdata = {8'h00, ctrl};
        REG_ENAB:  next_rdata = {12'h000, enab};
        REG_BAUD:  next_rdata = baud_div;
        REG_TXBUF: next_rdata = {8'h00, transmit_buffer};
        REG_RXBUF:
        begin
          next_rdata              = {8'h00, receive_buffer};
          next_receive_irq_flag   = 1'b0;
          next_framing_error_flag = 1'b0;
          next_parity_error_flag  = 1'b0;
          next_overrun_flag       = 1'b0;
          next_break_flag         = 1'b0;
        end
        REG_STAT:
        begin
          next_rdata = '0;
          next_rdata[S_RXF]  = receive_irq_flag;
          next_rdata[S_TXR]  = transmit_ready_flag;
          next_rdata[S_EMP]  = transmitter_empty_flag;
          next_rdata[S_RTAG] = received_address_tag;
          next_rdata[S_TREQ] = transmit_address_request;
          next_rdata[S_ERR]  = receive_error_summary;
          next_rdata[S_FE]   = framing_error_flag;
          next_rdata[S_PE]   = parity_error_flag;
          next_rdata[S_OE]   = overrun_flag;
          next_rdata[S_BRK]  = break_flag;
        end
        default:   next_rdata = '0;
      endcase
    end
    if (deliver)
    begin
      if (receive_irq_flag && !(rd_stb && addr == REG_RXBUF))
        next_overrun_flag = 1'b1;
      next_receive_buffer       = rx_word;
      next_receive_irq_flag     = 1'b1;
      next_received_address_tag = rx_is_addr;     // Address tag follows the buffer.
      if (rx_ferr) next_framing_error_flag = 1'b1; // Errors still flag on address.
      if (rx_perr) next_parity_error_flag = 1'b1;
      if (rx_brk)  next_break_flag = 1'b1;
    end
    next_transmitter_empty_flag = tx_idle_now && next_transmit_ready_flag;
    // Soft reset forces the flags and clears the irq enables, leaving the rx/tx enables alone.
    if (next_ctrl[C_SRST])
    begin
      next_enab[E_RXIE]             = 1'b0;
      next_enab[E_TXIE]             = 1'b0;
      next_receive_irq_flag         = 1'b0;
      next_received_address_tag     = 1'b0;
      next_transmit_address_request = 1'b0;
      next_framing_error_flag       = 1'b0;
      next_parity_error_flag        = 1'b0;
      next_overrun_flag             = 1'b0;
      next_break_flag               = 1'b0;
      next_transmit_ready_flag      = 1'b1;
      next_transmitter_empty_flag   = 1'b1;
    end
  end

  // Power-up clear leaves the block held in soft reset.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ctrl                     <= 8'h01;
      enab                     <= '0;
      baud_div                 <= BAUD_RESET;
      transmit_buffer          <= '0;
      receive_buffer           <= '0;
      receive_irq_flag         <= 1'b0;
      transmit_ready_flag      <= 1'b1;
      transmitter_empty_flag   <= 1'b1;
      received_address_tag     <= 1'b0;
      transmit_address_request <= 1'b0;
      framing_error_flag       <= 1'b0;
      parity_error_flag        <= 1'b0;
      overrun_flag             <= 1'b0;
      break_flag               <= 1'b0;
      rdata                    <= '0;
    end
    else if (ce)
    begin
      ctrl                     <= next_ctrl;
      enab                     <= next_enab;
      baud_div                 <= next_baud_div;
      transmit_buffer          <= next_transmit_buffer;
      receive_buffer           <= next_receive_buffer;
      receive_irq_flag         <= next_receive_irq_flag;
      transmit_ready_flag      <= next_transmit_ready_flag;
      transmitter_empty_flag   <= next_transmitter_empty_flag;
      received_address_tag     <= next_received_address_tag;
      transmit_address_request <= next_transmit_address_request;
      framing_error_flag       <= next_framing_error_flag;
      parity_error_flag        <= next_parity_error_flag;
      overrun_flag             <= next_overrun_flag;
      break_flag               <= next_break_flag;
      rdata                    <= next_rdata;
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  rx_state_t   rx_state, next_rx_state;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [3:0]  rx_bit, next_rx_bit, mark_cnt, next_mark_cnt;
  logic [7:0]  rx_shift, next_rx_shift;
  logic        rx_addr, next_rx_addr, rx_par, next_rx_par;
  logic        idle_seen, next_idle_seen, next_start_wake;
  logic [3:0]  nbits;

  assign nbits   = ctrl[C_CH8] ? BITS_LONG : BITS_SHORT;
  assign rx_word = ctrl[C_CH8] ? rx_shift : {1'b0, rx_shift[7:1]};
  // The address bit takes part in the parity sum.
  assign rx_perr = ctrl[C_PEN] &&
                   (rx_par != (^rx_word ^ (ctrl[C_MM] & rx_addr) ^ ctrl[C_PODD]));
  assign rx_ferr = !serial_in_pin;                      // Stop bit must be mark.
  assign rx_brk  = !serial_in_pin && rx_word == 8'h00 && !rx_addr;
  // Idle-line mode tags by idle; address-bit mode by the extra bit.
  assign rx_is_addr = ctrl[C_MM] ? rx_addr : idle_seen;

  // Bit sampler; the timer reloads from the shared divisor each bit.
  always_comb
  begin
    next_rx_state  = rx_state;
    next_rx_cnt    = (rx_cnt == '0) ? baud_div - 16'h0001 : rx_cnt - 16'h0001;
    next_rx_bit    = rx_bit;
    next_rx_shift  = rx_shift;
    next_rx_addr   = rx_addr;
    next_rx_par    = rx_par;
    next_mark_cnt  = mark_cnt;
    next_idle_seen = idle_seen;
    next_start_wake = 1'b0;
    rx_done        = 1'b0;
    case (rx_state)
      R_IDLE:
      begin
        if (!serial_in_pin)
        begin
          next_start_wake = 1'b1;                      // Start edge detect.
          next_mark_cnt   = '0;
          if (enab[E_RXE])
          begin
            next_rx_state = R_START;
            next_rx_cnt   = {1'b0, baud_div[15:1]} - 16'h0001;
          end
        end
        else if (rx_cnt == '0)
        begin
          // The second stop bit, if any, lands here as the first mark.
          if (mark_cnt != IDLE_MARKS)
            next_mark_cnt = mark_cnt + 4'h1;
          if (mark_cnt + 4'h1 >= IDLE_MARKS)
            next_idle_seen = 1'b1;
        end
      end
      R_START:
      begin
        if (rx_cnt == '0)
        begin
          next_rx_state = serial_in_pin ? R_IDLE : R_DATA;
          next_rx_bit   = '0;
        end
      end
      R_DATA:
      begin
        if (rx_cnt == '0)
        begin
          next_rx_shift = {serial_in_pin, rx_shift[7:1]};  // LSB arrives first.
          next_rx_bit   = rx_bit + 4'h1;
          if (rx_bit == nbits - 4'h1)
            next_rx_state = ctrl[C_MM] ? R_ADDR : (ctrl[C_PEN] ? R_PAR : R_STOP);
        end
      end
      R_ADDR:
      begin
        if (rx_cnt == '0)
        begin
          next_rx_addr  = serial_in_pin;
          next_rx_state = ctrl[C_PEN] ? R_PAR : R_STOP;
        end
      end
      R_PAR:
      begin
        if (rx_cnt == '0)
        begin
          next_rx_par   = serial_in_pin;
          next_rx_state = R_STOP;
        end
      end
      R_STOP:
      begin
        if (rx_cnt == '0)
        begin
          rx_done        = 1'b1;
          next_rx_state  = R_IDLE;
          next_mark_cnt  = '0;
          next_idle_seen = 1'b0;
        end
      end
      default: next_rx_state = R_IDLE;
    endcase
    if (!active)
    begin
      next_rx_state = R_IDLE;
      rx_done       = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rx_state   <= R_IDLE;
      rx_cnt     <= '0;
      rx_bit     <= '0;
      rx_shift   <= '0;
      rx_addr    <= 1'b0;
      rx_par     <= 1'b0;
      mark_cnt   <= '0;
      idle_seen  <= 1'b1;
      start_wake <= 1'b0;
    end
    else if (ce)
    begin
      rx_state   <= next_rx_state;
      rx_cnt     <= next_rx_cnt;
      rx_bit     <= next_rx_bit;
      rx_shift   <= next_rx_shift;
      rx_addr    <= next_rx_addr;
      rx_par     <= next_rx_par;
      mark_cnt   <= next_mark_cnt;
      idle_seen  <= next_idle_seen;
      start_wake <= next_start_wake;
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  tx_state_t   tx_state, next_tx_state;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic [3:0]  tx_bit, next_tx_bit;
  logic [7:0]  tx_shift, next_tx_shift;
  logic        wake_temp_latch, next_wut, tx_par, next_tx_par, next_serial_out;
  logic        tx_tick;

  assign tx_idle_now = tx_state == T_IDLE;
  assign tx_load     = tx_idle_now && active && enab[E_TXE] && !transmit_ready_flag;
  assign tx_tick     = tx_cnt == '0;

  // Frame sequencer; the line level is registered from the next state.
  always_comb
  begin
    next_tx_state   = tx_state;
    next_tx_cnt     = tx_tick ? baud_div - 16'h0001 : tx_cnt - 16'h0001;
    next_tx_bit     = tx_bit;
    next_tx_shift   = tx_shift;
    next_wut        = wake_temp_latch;
    next_tx_par     = tx_par;
    next_serial_out = serial_out_pin;
    case (tx_state)
      T_IDLE:
      begin
        next_serial_out = 1'b1;                          // Idle line is mark.
        if (tx_load)
        begin
          next_wut      = transmit_address_request;
          next_tx_shift = transmit_buffer;
          next_tx_par   = ^transmit_buffer ^ (ctrl[C_MM] & transmit_address_request) ^
                          ctrl[C_PODD];
          next_tx_cnt   = baud_div - 16'h0001;
          if (transmit_address_request && !ctrl[C_MM])
          begin
            // Dummy is dropped; a prior second stop bit counts toward the eleven.
            next_tx_state = T_MARK;
            next_tx_cnt   = baud_div - 16'h0002; // Load cycle is idle too.
            next_tx_bit   = ctrl[C_SP2] ? TX_IDLE_BITS - 4'h1 : TX_IDLE_BITS;
          end
          else
          begin
            next_tx_state   = T_START;
            next_serial_out = 1'b0;                      // Start bit is space.
          end
        end
      end
      T_START:
      begin
        if (tx_tick)
        begin
          next_tx_state   = T_DATA;
          next_tx_bit     = '0;
          next_serial_out = tx_shift[0];                 // LSB leaves first.
        end
      end
      T_DATA:
      begin
        if (tx_tick)
        begin
          next_tx_shift   = {1'b0, tx_shift[7:1]};
          next_tx_bit     = tx_bit + 4'h1;
          next_serial_out = tx_shift[1];
          if (tx_bit == nbits - 4'h1)
          begin
            next_tx_bit = '0;
            if (ctrl[C_MM])
            begin
              next_tx_state   = T_ADDR;
              next_serial_out = wake_temp_latch;                     // Address bit from the latch.
            end
            else if (ctrl[C_PEN])
            begin
              next_tx_state   = T_PAR;
              next_serial_out = tx_par;
            end
            else
            begin
              next_tx_state   = T_STOP;
              next_serial_out = 1'b1;
            end
          end
        end
      end
      T_ADDR:
      begin
        if (tx_tick)
        begin
          next_tx_state   = ctrl[C_PEN] ? T_PAR : T_STOP;
          next_serial_out = ctrl[C_PEN] ? tx_par : 1'b1;
        end
      end
      T_PAR:
      begin
        if (tx_tick)
        begin
          next_tx_state   = T_STOP;
          next_serial_out = 1'b1;
        end
      end
      T_STOP:
      begin
        if (tx_tick)
        begin
          next_tx_bit = tx_bit + 4'h1;
          if (!ctrl[C_SP2] || tx_bit != '0)
            next_tx_state = T_IDLE;
        end
      end
      T_MARK:
      begin
        next_serial_out = 1'b1;
        if (tx_tick)
        begin
          next_tx_bit = tx_bit - 4'h1;
          if (tx_bit == 4'h1)
            next_tx_state = T_IDLE;                      // Next load follows at once.
        end
      end
      default: next_tx_state = T_IDLE;
    endcase
    if (!active)
    begin
      next_tx_state   = T_IDLE;
      next_serial_out = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tx_state       <= T_IDLE;
      tx_cnt         <= '0;
      tx_bit         <= '0;
      tx_shift       <= '0;
      wake_temp_latch            <= 1'b0;
      tx_par         <= 1'b0;
      serial_out_pin <= 1'b1;
    end
    else if (ce)
    begin
      tx_state       <= next_tx_state;
      tx_cnt         <= next_tx_cnt;
      tx_bit         <= next_tx_bit;
      tx_shift       <= next_tx_shift;
      wake_temp_latch            <= next_wut;
      tx_par         <= next_tx_par;
      serial_out_pin <= next_serial_out;
    end
  end

endmodule // uart_idle_line

// ===== tb/uart_monitor.sv
// Port checker for the idle-line UART core.
`timescale 1ns/1ps
module uart_monitor
  import uart_pkg::*;
(
  input wire logic                    mclk, // Clock.
  input wire logic                    reset_n, // Reset.
  input wire logic                    ce, // Enable.
  input wire logic [uart_pkg::AW-1:0] addr, // Index.
  input wire logic [uart_pkg::DW-1:0] wdata, // Write data.
  input wire logic                    wr_stb, // Write.
  input wire logic                    rd_stb, // Read.
  input wire logic [uart_pkg::DW-1:0] rdata, // Read data.
  input wire logic                    serial_in_pin, // Rx line.
  input wire logic                    serial_out_pin, // Tx line.
  input wire logic                    receive_irq_flag, // Rx flag.
  input wire logic                    transmit_ready_flag, // Tx ready.
  input wire logic                    start_wake // Wake pulse.
);
  // All checks share the system clock and rest while reset is low.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // A buffer write and a soft reset request on the register port.
  sequence s_tx_wr;
    wr_stb && addr == REG_TXBUF && transmit_ready_flag;
  endsequence
  sequence s_srst_wr;
    wr_stb && addr == REG_CTRL && wdata[C_SRST];
  endsequence
  // Each property but a_bit_min_len, a_flag_holds and a_rdata_idle ties an output to the input event that caused it.
  a_wake_needs_low:
    assert property (start_wake |-> !$past(serial_in_pin))
    else $error("wake pulse without a low line");
  a_reset_levels:
    assert property ($rose(reset_n) |-> serial_out_pin && transmit_ready_flag && !receive_irq_flag)
    else $error("wrong levels after reset");
  a_bit_min_len:
    assert property ($changed(serial_out_pin) |=> $stable(serial_out_pin)[*3])
    else $error("tx bit shorter than one period");
  a_write_clears_ready:
    assert property (s_tx_wr |=> !transmit_ready_flag)
    else $error("buffer write left ready high");
  a_srst_flags:
    assert property (s_srst_wr |-> ##2 (transmit_ready_flag && !receive_irq_flag && serial_out_pin)[*2])
    else $error("soft reset did not set the flags");
  a_flag_holds:
    assert property (receive_irq_flag && !rd_stb && !wr_stb |=> receive_irq_flag)
    else $error("rx flag dropped by itself");
  a_read_clears:
    assert property (rd_stb && addr == REG_RXBUF |=> !receive_irq_flag)
    else $error("rx flag kept after buffer read");
  a_rdata_idle:
    assert property (!$past(rd_stb) |-> rdata == '0)
    else $error("read data outside the answer cycle");
endmodule // uart_monitor

bind uart_idle_line uart_monitor mon (.mclk, .reset_n, .ce, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata, .serial_in_pin, .serial_out_pin, .receive_irq_flag, .transmit_ready_flag, .start_wake);

// ===== tb/uart_node.sv
// Serial node model standing on the far side of the UART pins.
`timescale 1ns/1ps
module uart_node #(parameter int BIT = 4)
(
  input  wire logic       mclk, // Clock.
  input  wire logic       line_in, // Line from the block.
  output logic            line_out, // Line into the block.
  output logic [7:0]      got, // Last byte seen.
  output int              cnt // Bytes seen.
);
  int hi;
  int gaps [8];
  // The line idles at mark between frames, as a real pull-up holds it.
  initial line_out = 1'b1;
  // Mark cycles are counted so the bench can time idle periods exactly.
  always @(posedge mclk) hi <= line_in ? hi + 1 : 0;
  // Bits are sampled mid-period, least significant first.
  initial
  begin
    cnt = 0;
    forever
    begin
      @(posedge mclk);
      #1;
      if (line_in === 1'b0)
      begin
        gaps[cnt % 8] = hi;
        repeat (BIT / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT) @(posedge mclk);
          #1 got = {line_in, got[7:1]};
        end
        repeat (BIT) @(posedge mclk);
        cnt++;
      end
    end
  end
  // Sends one 8-bit frame after the given number of idle bits.
  task automatic send(input logic [7:0] d, input int idle);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    repeat (idle * BIT) @(posedge mclk);
    for (int i = 0; i < 10; i++)
    begin
      line_out <= f[i];
      repeat (BIT) @(posedge mclk);
    end
  endtask
endmodule // uart_node

// ===== tb/tb.sv
// Self-checking bench for the idle-line UART core.
`timescale 1ns/1ps
module tb;
  import uart_pkg::*;
  localparam int BIT = 4;
  logic          mclk = 1'b0;
  logic          reset_n = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic          wr_stb = 1'b0;
  logic          rd_stb = 1'b0;
  logic [DW-1:0] rdata, v;
  logic          serial_in_pin, serial_out_pin, receive_irq_flag, transmit_ready_flag, start_wake;
  int            errors = 0, checked = 0;
  // Free-running 50 MHz system clock.
  always #10 mclk = ~mclk;
  uart_idle_line dut (.mclk, .reset_n, .ce(1'b1), .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .serial_in_pin, .serial_out_pin, .receive_irq_flag, .transmit_ready_flag, .start_wake);
  uart_node #(.BIT(BIT)) node (.mclk, .line_in(serial_out_pin), .line_out(serial_in_pin),
    .got(), .cnt());
  // Comparison and register port helpers shared by every scenario.
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  // Bounded wait on transmit ready (rx low) or the receive flag (rx high).
  task automatic wait_for(input bit rx);
    repeat (2000)
    begin
      @(posedge mclk);
      #1;
      if ((rx ? receive_irq_flag : transmit_ready_flag) === 1'b1) return;
    end
    errors++;
  endtask
  task automatic t_reset();
    rd(REG_CTRL);
    chk("ctrl", v, 16'h0001);
    rd(REG_STAT);
    chk("status", v, 16'h0006);
    rd(3'h7);
    chk("unmapped", v, 16'h0000);
  endtask
  // Irq enables are held clear under soft reset; the enables survive.
  task automatic t_init();
    wr(REG_ENAB, 16'h000F);
    rd(REG_ENAB);
    chk("enab", v, 16'h0003);
    wr(REG_BAUD, 16'h0004);
    wr(REG_CTRL, 16'h0003);
    wr(REG_CTRL, 16'h0002);
    wr(REG_ENAB, 16'h000F);
  endtask
  // Back-to-back bytes, then an idle frame with a dummy that must vanish.
  task automatic t_tx();
    wr(REG_TXBUF, 16'h0012);
    wait_for(1'b0);
    wr(REG_TXBUF, 16'h0034);
    wait_for(1'b0);
    wr(REG_STAT, 16'h0010);
    wr(REG_TXBUF, 16'h00FF);
    wait_for(1'b0);
    rd(REG_STAT);
    chk("addr request", 16'(v[S_TREQ]), 16'h0000);
    wr(REG_TXBUF, 16'h0081);
    for (int i = 0; i < 900 && node.cnt < 3; i++)
      @(posedge mclk);
    chk("bytes out", 16'(node.cnt), 16'h0003);
    chk("last byte", {8'h00, node.got}, 16'h0081);
    chk("idle gap", 16'(node.gaps[2] - node.gaps[1]), 16'(11 * BIT));
  endtask
  task automatic t_rx();
    node.send(8'h3C, 12);
    wait_for(1'b1);
    rd(REG_STAT);
    chk("address tag", 16'(v[S_RTAG]), 16'h0001);
    rd(REG_RXBUF);
    chk("rx byte", v, 16'h003C);
  endtask
  // The filter passes the address, drops the close follower, stays set.
  task automatic t_filter();
    wr(REG_CTRL, 16'h0082);
    node.send(8'h11, 12);
    wait_for(1'b1);
    rd(REG_RXBUF);
    chk("address byte", v, 16'h0011);
    node.send(8'h22, 0);
    #41;
    chk("filtered flag", 16'(receive_irq_flag), 16'h0000);
    rd(REG_CTRL);
    chk("filter bit", v, 16'h0082);
    wr(REG_CTRL, 16'h0002);
    node.send(8'h33, 0);
    wait_for(1'b1);
    rd(REG_STAT);
    chk("data tag", 16'(v[S_RTAG]), 16'h0000);
  endtask
  // Soft reset with a character still waiting clears it and keeps the rx/tx enables.
  task automatic t_srst();
    wr(REG_CTRL, 16'h0003);
    rd(REG_ENAB);
    chk("enab kept", v, 16'h0003);
    rd(REG_STAT);
    chk("status", v, 16'h0006);
  endtask
  task automatic wrap_up();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence after 16 cycles of reset.
  initial
  begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_init();
    t_tx();
    t_rx();
    t_filter();
    t_srst();
    wrap_up();
  end
  // Watchdog at 10,000 cycles, well beyond the few hundred cycles the scenarios need.
  initial
  begin
    #200_000;
    errors++;
    wrap_up();
  end
endmodule // tb
